// File: phy_connection_manager.sv
// Physical connection management state machine with its APB registers.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module phy_connection_manager import phy_cm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line side
  input wire logic [2:0] line_condition_code,
  output logic [2:0] line_transmit_port,
  output logic loopback_en,
  output logic station_inserted
);

  pcm_state_e state_q;
  pcm_state_e state_d;
  logic [2:0] reason_d;
  logic [2:0] brk_reason_q;
  logic restart_ok_q;
  logic [3:0] tx_len_q;
  logic [15:0] tx_vec_q;
  logic [15:0] rx_vec_q;
  logic [3:0] bit_idx_q;
  logic sig_q;
  logic tdf_q;
  logic [15:0] noise_time_q;
  logic [15:0] short_dur_q;
  logic long_q;
  logic noise_run_q;
  logic [1:0] loop_mode_q;
  logic lct_q;
  logic [15:0] lct_cnt_q;
  logic [15:0] tne_q;
  logic idle_q;
  logic ls_flag_q;
  logic [4:0] evt_q;
  logic [4:0] evt_set;
  ctrl_s cw;
  status_s st;

  // Register writes happen only in the access phase that ends the transfer.
  wire wr_en = psel & penable & pready & pwrite;
  wire wr_ctrl = wr_en && (paddr == ADDR_CTRL);
  wire wr_vec = wr_en && (paddr == ADDR_TXVEC);
  assign cw = ctrl_s'(pwdata[CTRL_W-1:0]);
  wire start_cmd = wr_ctrl & cw.connect_begin_cmd;
  wire stop_cmd = wr_ctrl & cw.stop;
  wire join_cmd = wr_ctrl & cw.join_cmd;
  wire trace_request = wr_ctrl & cw.trace_request;
  wire loop_wr = wr_ctrl & (cw.loop_test_bits != 2'h0);
  wire loop_ok = loop_wr && (state_q == ST_NEXT) && !sig_q;
  wire join_ok = join_cmd && (state_q == ST_NEXT) && !sig_q;

  // The line condition comes from the line state logic on this clock.
  wire [2:0] ls = line_condition_code;
  wire rx_idle = (ls == LS_IDLE) || (ls == LS_LIDLE);
  wire rx_hm = (ls == LS_HALT) || (ls == LS_MASTER);
  wire rx_bit_seen = (state_q == ST_SIGNAL) && rx_hm;
  wire last_bit = bit_idx_q == tx_len_q;
  wire tne_cnt_en = ((state_q == ST_ACTIVE) && ls_flag_q) || ((state_q == ST_MAINT) && noise_run_q);
  wire tne_exp = !rx_idle && !idle_q && tne_cnt_en && (tne_q == 16'h0001);
  wire lct_done = lct_q && ((!long_q && (lct_cnt_q == 16'h0000)) || rx_hm);
  wire brk_entry = (state_d == ST_BREAK) && ((state_q != ST_BREAK) || start_cmd);

  // Next state. Stop wins over start so software can always park the port.
  always_comb begin
    state_d = state_q;
    reason_d = RSN_START;
    if (stop_cmd) begin
      state_d = ST_OFF;
    end else if (start_cmd) begin
      state_d = ST_BREAK;
    end else begin
      unique case (state_q)
        ST_OFF: state_d = (wr_ctrl && cw.maint) ? ST_MAINT : ST_OFF;
        ST_BREAK: state_d = restart_ok_q ? ST_CONNECT : ST_BREAK;
        ST_CONNECT: state_d = (ls == LS_HALT) ? ST_NEXT : ST_CONNECT;
        // Waiting for the far end's idle keeps a stale answer from passing as the next bit.
        ST_NEXT: state_d = join_ok ? ST_JOIN : ((sig_q && rx_idle) ? ST_SIGNAL : ST_NEXT);
        ST_SIGNAL: state_d = rx_bit_seen ? ST_NEXT : ST_SIGNAL;
        ST_JOIN: state_d = (ls == LS_HALT) ? ST_VERIFY : ST_JOIN;
        ST_VERIFY: state_d = rx_idle ? ST_ACTIVE : ST_VERIFY;
        ST_ACTIVE: begin
          if (trace_request) begin
            state_d = ST_TRACE;
          end else if (tne_exp) begin
            state_d = ST_BREAK;
            reason_d = RSN_NOISE;
          end
        end
        ST_TRACE: begin
          if ((ls == LS_QUIET) || (ls == LS_HALT)) begin
            state_d = ST_BREAK;
            reason_d = RSN_TRACE;
          end
        end
        ST_MAINT: state_d = ST_MAINT;
        default: state_d = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Only a start arms the restart, so software may reload vectors after a fault.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      restart_ok_q <= 1'b0;
      brk_reason_q <= RSN_NONE;
    end else if (brk_entry) begin
      restart_ok_q <= start_cmd;
      brk_reason_q <= reason_d;
    end else if (state_q == ST_CONNECT) begin
      restart_ok_q <= 1'b0;
    end
  end

  // Signaling: one bit per visit to the signal state, answer captured on return.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sig_q <= 1'b0;
      bit_idx_q <= 4'h0;
      rx_vec_q <= 16'h0000;
      tdf_q <= 1'b0;
    end else if (start_cmd || stop_cmd) begin
      sig_q <= 1'b0;
      tdf_q <= 1'b0;
    end else if ((state_q == ST_CONNECT && state_d == ST_NEXT) || (wr_vec && state_q == ST_NEXT)) begin
      sig_q <= 1'b1;
      bit_idx_q <= 4'h0;
      rx_vec_q <= 16'h0000;
      tdf_q <= 1'b0;
    end else if (rx_bit_seen && sig_q) begin
      rx_vec_q[bit_idx_q] <= ls == LS_HALT;
      bit_idx_q <= bit_idx_q + 4'h1;
      if (last_bit) begin
        sig_q <= 1'b0;
        tdf_q <= 1'b1;
      end
    end else if (loop_ok) begin
      tdf_q <= 1'b1;
    end
  end

  // Link confidence test.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lct_q <= 1'b0;
      lct_cnt_q <= 16'h0000;
      loop_mode_q <= 2'h0;
    end else if (loop_ok) begin
      lct_q <= 1'b1;
      loop_mode_q <= cw.loop_test_bits;
      lct_cnt_q <= short_dur_q;
    end else if (lct_done || join_ok || wr_vec || start_cmd || stop_cmd) begin
      lct_q <= 1'b0;
      loop_mode_q <= 2'h0;
    end else if (lct_q && lct_cnt_q != 16'h0000) begin
      lct_cnt_q <= lct_cnt_q - 16'h0001;
    end
  end

  // Noise timer. Reset treats the line as idle so the first noise reloads it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tne_q <= 16'h0000;
      idle_q <= 1'b1;
    end else begin
      idle_q <= rx_idle;
      if (wr_en && paddr == ADDR_TNE && state_q == ST_MAINT && !noise_run_q) begin
        tne_q <= pwdata[15:0];
      end else if (!rx_idle && idle_q) begin
        tne_q <= noise_time_q;
      end else if (!rx_idle && tne_cnt_en && tne_q != 16'h0000) begin
        tne_q <= tne_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ls_flag_q <= 1'b0;
    end else if (state_q != ST_ACTIVE) begin
      ls_flag_q <= 1'b0;
    end else if (rx_idle) begin
      ls_flag_q <= 1'b1;
    end
  end

  // Sticky events; a set in the same cycle as its clear wins.
  always_comb begin
    evt_set = 5'h00;
    evt_set[EV_CODE] = (rx_bit_seen && sig_q && last_bit) || lct_done;
    evt_set[EV_BREAK] = brk_entry;
    evt_set[EV_NOISE] = tne_exp && (state_q == ST_MAINT);
    evt_set[EV_TRACE] = (state_q == ST_ACTIVE) && (ls == LS_MASTER || trace_request);
    evt_set[EV_SELF] = (state_q == ST_TRACE) && (ls == LS_QUIET || ls == LS_HALT);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt_q <= 5'h00;
    end else if (wr_en && paddr == ADDR_EVENTS) begin
      evt_q <= (evt_q & ~pwdata[4:0]) | evt_set;
    end else begin
      evt_q <= evt_q | evt_set;
    end
  end

  // Software parameters; loaded by writes in any state of the machine.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_len_q <= 4'h0;
      tx_vec_q <= 16'h0000;
      noise_time_q <= NOISE_TIME_RST;
      short_dur_q <= SHORT_DUR_RST;
      long_q <= 1'b0;
      noise_run_q <= 1'b0;
    end else if (wr_en) begin
      unique case (paddr)
        ADDR_TXLEN: tx_len_q <= pwdata[3:0];
        ADDR_TXVEC: tx_vec_q <= pwdata[15:0];
        ADDR_NOISE: noise_time_q <= pwdata[15:0];
        ADDR_SHORT: short_dur_q <= pwdata[15:0];
        ADDR_CTRL: begin
          long_q <= cw.long_test;
          noise_run_q <= cw.noise_run;
        end
        default: begin
        end
      endcase
    end
  end

  // Transmit request follows the state one cycle later.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_transmit_port <= TX_QUIET;
      loopback_en <= 1'b0;
      station_inserted <= 1'b0;
    end else begin
      loopback_en <= lct_q && (loop_mode_q == LOOP_REMOTE);
      station_inserted <= (state_q == ST_ACTIVE) || (state_q == ST_TRACE);
      unique case (state_q)
        ST_CONNECT, ST_JOIN: line_transmit_port <= TX_HALT;
        ST_SIGNAL: line_transmit_port <= tx_vec_q[bit_idx_q] ? TX_HALT : TX_MASTER;
        ST_VERIFY, ST_TRACE: line_transmit_port <= TX_MASTER;
        ST_ACTIVE: line_transmit_port <= TX_DATA;
        ST_NEXT: line_transmit_port <= (lct_q && loop_mode_q != LOOP_IDLE) ? TX_DATA : TX_IDLE;
        default: line_transmit_port <= TX_QUIET;
      endcase
    end
  end

  assign st = {lct_q, sig_q, tdf_q, brk_reason_q, state_q};

  // APB answers in the first access cycle; unmapped addresses return an error.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      unique case (paddr)
        ADDR_CTRL: prdata <= {23'h0, noise_run_q, long_q, loop_mode_q, 5'h00};
        ADDR_TXLEN: prdata <= {28'h0, tx_len_q};
        ADDR_TXVEC: prdata <= {16'h0, tx_vec_q};
        ADDR_RXVEC: prdata <= {16'h0, rx_vec_q};
        ADDR_NOISE: prdata <= {16'h0, noise_time_q};
        ADDR_SHORT: prdata <= {16'h0, short_dur_q};
        ADDR_STATUS: prdata <= {22'h0, st};
        ADDR_EVENTS: prdata <= {27'h0, evt_q};
        ADDR_TNE: prdata <= {16'h0, tne_q};
        default: pslverr <= 1'b1;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  wire quiet_cmd = !start_cmd && !stop_cmd;

  property p_start_break;
    start_cmd && !stop_cmd |=> state_q == ST_BREAK ##1 state_q == ST_CONNECT;
  endproperty
  a_start_break: assert property (p_start_break) else $error("start did not pass break to connect");

  property p_brk_evt;
    brk_entry |=> evt_q[EV_BREAK] && state_q == ST_BREAK;
  endproperty
  a_brk_evt: assert property (p_brk_evt) else $error("break entry without break event");

  property p_brk_hold;
    state_q == ST_BREAK && !restart_ok_q && quiet_cmd |=> state_q == ST_BREAK;
  endproperty
  a_brk_hold: assert property (p_brk_hold) else $error("break left without start");

  property p_last_bit;
    rx_bit_seen && sig_q && last_bit && quiet_cmd && !wr_vec |=> !sig_q && evt_q[EV_CODE] && state_q == ST_NEXT;
  endproperty
  a_last_bit: assert property (p_last_bit) else $error("last bit did not complete signaling");

  property p_loop_ignored;
    loop_wr && !lct_q && (state_q != ST_NEXT || sig_q) |=> !lct_q;
  endproperty
  a_loop_ignored: assert property (p_loop_ignored) else $error("loop accepted outside idle next");

  property p_short_end;
    lct_q && !long_q && lct_cnt_q == 16'h0000 && !loop_wr |=> !lct_q && evt_q[EV_CODE];
  endproperty
  a_short_end: assert property (p_short_end) else $error("short test did not end");

  property p_join_abort;
    join_ok && lct_q && quiet_cmd |=> state_q == ST_JOIN && !lct_q;
  endproperty
  a_join_abort: assert property (p_join_abort) else $error("join did not abort test");

  property p_join_refused;
    join_cmd && state_q == ST_NEXT && sig_q |=> state_q != ST_JOIN;
  endproperty
  a_join_refused: assert property (p_join_refused) else $error("join taken while signaling");

  property p_noise_break;
    state_q == ST_ACTIVE && tne_exp && !trace_request && quiet_cmd |=> state_q == ST_BREAK && brk_reason_q == RSN_NOISE;
  endproperty
  a_noise_break: assert property (p_noise_break) else $error("noise expiry did not break");

  property p_trace_wins;
    state_q == ST_ACTIVE && trace_request && quiet_cmd |=> state_q == ST_TRACE ##2 line_transmit_port == TX_MASTER;
  endproperty
  a_trace_wins: assert property (p_trace_wins) else $error("trace request not taken");

  property p_self_test;
    state_q == ST_TRACE && (ls == LS_QUIET || ls == LS_HALT) |=> evt_q[EV_SELF];
  endproperty
  a_self_test: assert property (p_self_test) else $error("self-test event missing");

  c_active: cover property (state_q == ST_VERIFY ##1 state_q == ST_ACTIVE);
  c_trace: cover property (state_q == ST_ACTIVE ##1 state_q == ST_TRACE);
  c_lct_end: cover property (lct_q ##1 !lct_q && evt_q[EV_CODE]);
  c_noise: cover property (state_q == ST_ACTIVE && tne_exp);

endmodule
`default_nettype wire

// File: phy_cm_pkg.sv
// Constants, types and register map of the physical connection manager.
package phy_cm_pkg;

  typedef enum logic [3:0] {
    ST_OFF = 4'h0,
    ST_BREAK = 4'h1,
    ST_TRACE = 4'h2,
    ST_CONNECT = 4'h3,
    ST_NEXT = 4'h4,
    ST_SIGNAL = 4'h5,
    ST_JOIN = 4'h6,
    ST_VERIFY = 4'h7,
    ST_ACTIVE = 4'h8,
    ST_MAINT = 4'h9
  } pcm_state_e;

  // Received line condition codes.
  localparam logic [2:0] LS_NOISE = 3'h0;
  localparam logic [2:0] LS_ACTIVE = 3'h1;
  localparam logic [2:0] LS_IDLE = 3'h3;
  localparam logic [2:0] LS_QUIET = 3'h4;
  localparam logic [2:0] LS_MASTER = 3'h5;
  localparam logic [2:0] LS_HALT = 3'h6;
  localparam logic [2:0] LS_LIDLE = 3'h7;

  // Symbol requests on the transmit port.
  localparam logic [2:0] TX_QUIET = 3'h0;
  localparam logic [2:0] TX_IDLE = 3'h1;
  localparam logic [2:0] TX_HALT = 3'h2;
  localparam logic [2:0] TX_MASTER = 3'h3;
  localparam logic [2:0] TX_DATA = 3'h6;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TXLEN = 8'h04;
  localparam logic [7:0] ADDR_TXVEC = 8'h08;
  localparam logic [7:0] ADDR_RXVEC = 8'h0C;
  localparam logic [7:0] ADDR_NOISE = 8'h10;
  localparam logic [7:0] ADDR_SHORT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_EVENTS = 8'h1C;
  localparam logic [7:0] ADDR_TNE = 8'h20;

  // Values after reset.
  localparam logic [15:0] NOISE_TIME_RST = 16'h0100;
  localparam logic [15:0] SHORT_DUR_RST = 16'h0400;

  // Event bit positions.
  localparam int EV_CODE = 0;
  localparam int EV_BREAK = 1;
  localparam int EV_NOISE = 2;
  localparam int EV_TRACE = 3;
  localparam int EV_SELF = 4;

  // Break reasons.
  localparam logic [2:0] RSN_NONE = 3'h0;
  localparam logic [2:0] RSN_START = 3'h1;
  localparam logic [2:0] RSN_NOISE = 3'h2;
  localparam logic [2:0] RSN_TRACE = 3'h3;

  // Loop test functions.
  localparam logic [1:0] LOOP_PATTERN = 2'h1;
  localparam logic [1:0] LOOP_IDLE = 2'h2;
  localparam logic [1:0] LOOP_REMOTE = 2'h3;

  localparam int CTRL_W = 9;

  typedef struct packed {
    logic noise_run;
    logic long_test;
    logic [1:0] loop_test_bits;
    logic maint;
    logic stop;
    logic trace_request;
    logic join_cmd;
    logic connect_begin_cmd;
  } ctrl_s;

  typedef struct packed {
    logic lct;
    logic signaling;
    logic transmit_done_flag;
    logic [2:0] reason;
    pcm_state_e state;
  } status_s;

endpackage

// File: phy_remote_model.sv
// Behavioural model of the remote station's connection logic on the line.
`timescale 1ns/1ns
`default_nettype none
module phy_remote_model import phy_cm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Local symbol request and bench control
  input wire logic [2:0] tx_sym,
  input wire logic hold_en,
  input wire logic [2:0] hold_code,
  input wire logic [1:0] lag,
  // Line state seen by the block
  output logic [2:0] line_code
);
  logic [2:0] pipe_q [4];
  logic [2:0] echo;

  // The remote mirrors every symbol, so its answered bits equal the bits we sent.
  always_comb begin
    case (tx_sym)
      TX_HALT: echo = LS_HALT;
      TX_MASTER: echo = LS_MASTER;
      TX_IDLE: echo = LS_IDLE;
      TX_DATA: echo = LS_ACTIVE;
      default: echo = LS_QUIET;
    endcase
  end

  // A longer lag models a slow far end that answers several cycles late.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pipe_q <= '{default: LS_QUIET};
    end else begin
      pipe_q <= '{echo, pipe_q[0], pipe_q[1], pipe_q[2]};
    end
  end

  assign line_code = hold_en ? hold_code : pipe_q[lag];
endmodule
`default_nettype wire

// File: phy_connection_manager_tb.sv
// Self-checking testbench of the physical connection manager.
`timescale 1ns/1ns
`default_nettype none
module phy_connection_manager_tb import phy_cm_pkg::*;;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, loopback_en, station_inserted;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] line_code, tx_sym, hold_code;
  logic hold_en;
  logic [1:0] lag;
  logic [3:0] len;
  logic [15:0] vec;
  int fail_count, samples_checked;

  phy_connection_manager dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_condition_code(line_code), .line_transmit_port(tx_sym), .loopback_en(loopback_en),
    .station_inserted(station_inserted));

  phy_remote_model far_end (.clk(clk), .resetn(resetn), .tx_sym(tx_sym), .hold_en(hold_en),
    .hold_code(hold_code), .lag(lag), .line_code(line_code));

  function automatic logic [31:0] exp_rx(input logic [15:0] v, input logic [3:0] n);
    exp_rx = {16'h0, v & 16'((17'h1 << (n + 1)) - 1)};
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // The request is held until pready is sampled high, then released.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_reg(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] val);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0);
      k++;
    end while ((r & mask) !== val && k < 3000);
    chk(r & mask, val);
  endtask

  task automatic wait_st(input pcm_state_e s);
    wait_reg(ADDR_STATUS, 32'h0000000F, {28'h0, s});
  endtask

  task automatic wait_ev(input int b);
    wait_reg(ADDR_EVENTS, 32'h1 << b, 32'h1 << b);
    apb(1'b1, ADDR_EVENTS, 32'h1 << b);
  endtask

  // Loads a vector, optionally starts, and checks what came back from the far end.
  task automatic send_bits(input logic start);
    len = 4'($urandom_range(15));
    vec = 16'($urandom);
    lag <= 2'($urandom_range(1));
    apb(1'b1, ADDR_TXLEN, {28'h0, len});
    apb(1'b1, ADDR_TXVEC, {16'h0, vec});
    if (start) begin
      apb(1'b1, ADDR_CTRL, 32'h00000001);
    end
    wait_ev(EV_CODE);
    apb(1'b0, ADDR_RXVEC, 32'h0);
    chk(r, exp_rx(vec, len));
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[3:0], ST_NEXT);
  endtask

  task automatic join_up();
    hold_en <= 1'b1;
    hold_code <= LS_IDLE;
    apb(1'b1, ADDR_CTRL, 32'h00000002);
    wait_st(ST_JOIN);
    hold_code <= LS_HALT;
    wait_st(ST_VERIFY);
    hold_code <= LS_IDLE;
    wait_st(ST_ACTIVE);
    chk(tx_sym, TX_DATA);
    chk(station_inserted, 1'b1);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    resetn = 1'b0;
    {psel, penable, pwrite, hold_en} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hold_code = LS_IDLE;
    lag = 2'h0;
    fail_count = 0;
    samples_checked = 0;
    void'($urandom(61949));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, ADDR_NOISE, 32'h0);
    chk(r, {16'h0, NOISE_TIME_RST});
    apb(1'b0, ADDR_SHORT, 32'h0);
    chk(r, {16'h0, SHORT_DUR_RST});
    apb(1'b0, 8'h24, 32'h0);
    chk(r, 32'h0);
    chk(pslverr, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h00000062);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r, 32'h0);
    send_bits(1'b1);
    chk(r[6:4], RSN_START);
    apb(1'b0, ADDR_EVENTS, 32'h0);
    chk(r[EV_BREAK], 1'b1);
    send_bits(1'b0);
    hold_en <= 1'b1;
    hold_code <= LS_IDLE;
    apb(1'b1, ADDR_SHORT, 32'h00000014);
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, ADDR_CTRL, 32'(m) << 5);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(r[9:7], 3'b101);
      chk(loopback_en, m == 3);
      chk(tx_sym, (m == 2) ? TX_IDLE : TX_DATA);
      wait_ev(EV_CODE);
      chk(loopback_en, 1'b0);
    end
    apb(1'b1, ADDR_CTRL, 32'h000000A0);
    repeat (80) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[9], 1'b1);
    hold_code <= LS_HALT;
    wait_ev(EV_CODE);
    hold_code <= LS_IDLE;
    apb(1'b1, ADDR_CTRL, 32'h000000A0);
    repeat (20) @(posedge clk);
    join_up();
    apb(1'b1, ADDR_CTRL, 32'h00000004);
    wait_st(ST_TRACE);
    repeat (2) @(posedge clk);
    chk(tx_sym, TX_MASTER);
    chk(station_inserted, 1'b1);
    apb(1'b0, ADDR_EVENTS, 32'h0);
    chk(r[EV_TRACE], 1'b1);
    hold_code <= LS_QUIET;
    wait_ev(EV_SELF);
    wait_st(ST_BREAK);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[6:4], RSN_TRACE);
    hold_en <= 1'b0;
    repeat (50) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[3:0], ST_BREAK);
    apb(1'b1, ADDR_CTRL, 32'h00000008);
    wait_st(ST_OFF);
    apb(1'b1, ADDR_NOISE, 32'h00000008);
    send_bits(1'b1);
    join_up();
    apb(1'b1, ADDR_EVENTS, 32'h1 << EV_TRACE);
    hold_code <= LS_MASTER;
    wait_ev(EV_TRACE);
    hold_code <= LS_NOISE;
    wait_st(ST_BREAK);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[6:4], RSN_NOISE);
    apb(1'b1, ADDR_CTRL, 32'h00000008);
    wait_st(ST_OFF);
    apb(1'b1, ADDR_CTRL, 32'h00000010);
    wait_st(ST_MAINT);
    apb(1'b1, ADDR_TNE, 32'h00000055);
    apb(1'b0, ADDR_TNE, 32'h0);
    chk(r, 32'h00000055);
    hold_code <= LS_IDLE;
    apb(1'b1, ADDR_CTRL, 32'h00000110);
    hold_code <= LS_NOISE;
    wait_ev(EV_NOISE);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[3:0], ST_MAINT);
    give_verdict();
  end
endmodule
`default_nettype wire
